// ===== include/cvlp_consts.svh
`ifndef CVLP_CONSTS_SVH
`define CVLP_CONSTS_SVH

// Register indexes as printed; byte address is four times the index
`define CVLP_IDX_BUCK1_SLEEP   8'hb6
`define CVLP_IDX_CONV2_CTRL    8'hb7
`define CVLP_IDX_SW_SLEEP      8'hc0
`define CVLP_ADDR_BUCK1_SLEEP  12'h2d8
`define CVLP_ADDR_CONV2_CTRL   12'h2dc
`define CVLP_ADDR_SW_SLEEP     12'h300

// Field positions
`define CVLP_B1_ACT_HI         14
`define CVLP_B1_ACT_LO         12
`define CVLP_SRC_HI            9
`define CVLP_SRC_LO            8
`define CVLP_B1_ALT_HI         6
`define CVLP_B1_ALT_LO         0
`define CVLP_C2_TOPO_BIT       14
`define CVLP_C2_ACT_BIT        12
`define CVLP_C2_ILIM_BIT       6
`define CVLP_C2_RMPH_BIT       4
`define CVLP_C2_RMPL_BIT       3
`define CVLP_C2_FB_HI          1
`define CVLP_C2_FB_LO          0

// Writable bit masks and reset values
`define CVLP_B1_MASK           16'h737f
`define CVLP_C2_MASK           16'h535b
`define CVLP_B1_RESET          16'h1006
`define CVLP_C2_RESET          16'h0018

// Action, feedback and ramp codes
`define CVLP_ACT_KEEP          3'h0
`define CVLP_ACT_ALT           3'h1
`define CVLP_ACT_STBY          3'h2
`define CVLP_ACT_STBY_ALT      3'h3
`define CVLP_ACT_LDO           3'h4
`define CVLP_ACT_LDO_ALT       3'h5
`define CVLP_ACT_RSVD          3'h6
`define CVLP_ACT_OFF           3'h7
`define CVLP_FB_EXT            2'h0
`define CVLP_FB_SINK           2'h1
`define CVLP_FB_RSVD           2'h2
`define CVLP_FB_BUS            2'h3
`define CVLP_RAMP_LOWEST       2'h3

`endif

// ===== include/cvlp_pkg.sv
package cvlp_pkg;

    typedef enum logic [1:0] {
        CVLP_FB_EXT_DIV,
        CVLP_FB_SINK_A,
        CVLP_FB_BUS_DIV
    } cvlp_fb_type;

    typedef struct packed {
        logic       sleep_req;
        logic       alt_voltage_en;
        logic       force_standby;
        logic       force_ldo;
        logic       output_off;
        logic [6:0] alt_voltage_code;
    } cvlp_buck1_type;

    typedef struct packed {
        logic        sleep_req;
        logic        switch_mode;
        logic        output_off;
        logic        low_peak_limit;
        logic [1:0]  ramp_code;
        cvlp_fb_type feedback;
    } cvlp_conv2_type;

endpackage

// ===== rtl/cvlp_src_sel.sv
`timescale 1ns/100ps
`include "cvlp_consts.svh"

// Picks one sleep request source; a GPIO sleep input overrides the select
module cvlp_src_sel (
    input  wire logic [1:0] sel_i,
    input  wire logic       sw_sleep_i,
    input  wire logic [2:0] lowpower_line_i,
    input  wire logic       gpio_sleep_i,
    output logic            sleep_req_o
);

    logic picked;

    always_comb begin
        unique case (sel_i)
            2'h0: picked = sw_sleep_i;
            2'h1: picked = lowpower_line_i[0];
            2'h2: picked = lowpower_line_i[1];
            2'h3: picked = lowpower_line_i[2];
        endcase
    end

    assign sleep_req_o = picked | gpio_sleep_i;

endmodule

// ===== rtl/cvlp_regs.sv
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "cvlp_consts.svh"

// Behaviour
// - Buck1 action 000 keeps settings, 001 selects the alternate voltage, 111 turns output off.
// - Buck1 action 010 forces standby and 011 forces standby with the alternate voltage.
// - Buck1 action 100 forces linear mode, 101 adds the alternate voltage, 110 is reserved.
// - Buck1 source 00 is the software sleep bit, 01..11 are low-power lines one to three.
// - An asserted GPIO sleep input requests sleep whatever the source select holds.
// - The buck1 alternate code is 25 mV per step from 0.85 V, maximum 3.4 V at 0x66.
// - Converter 2 runs boost when its topology bit is 0 and switch mode when it is 1.
// - In sleep converter 2 keeps running when its action bit is 0 and turns off when 1.
// - Converter 2 source 00 is the software sleep bit, 01..11 are low-power lines one to three.
// - Converter 2 limit bit 0 selects the higher peak current and 1 the lower.
// - The converter 2 ramp code is the high ramp bit joined with the low ramp bit.
// - Feedback select 11 forces ramp code 11 whatever the ramp bits hold.
// - Feedback 00 is the divider pin, 01 current sink A, 11 the bus divider, 10 reserved.
// - A reset from the power state machine restores every field default.
module cvlp_regs #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   psm_reset_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [ADDR_W-1:0]      paddr_i,
    input  wire logic [31:0]            pwdata_i,
    input  wire logic [3:0]             pstrb_i,
    output logic                        pready_o,
    output logic [31:0]                 prdata_o,
    output logic                        pslverr_o,
    input  wire logic [2:0]             lowpower_line_i,
    input  wire logic                   gpio_sleep_i,
    output cvlp_pkg::cvlp_buck1_type    buck1_o,
    output cvlp_pkg::cvlp_conv2_type    conv2_o
);

    logic [15:0]              buck1_r;
    logic [15:0]              buck1_nxt;
    logic [15:0]              conv2_r;
    logic [15:0]              conv2_nxt;
    logic                     sw_sleep_r;
    logic                     sw_sleep_nxt;
    logic [31:0]              prdata_r;
    logic [31:0]              prdata_nxt;
    logic                     rd_wait_r;
    logic                     rd_wait_nxt;
    cvlp_pkg::cvlp_buck1_type buck1_out_r;
    cvlp_pkg::cvlp_buck1_type buck1_out_nxt;
    cvlp_pkg::cvlp_conv2_type conv2_out_r;
    cvlp_pkg::cvlp_conv2_type conv2_out_nxt;

    logic        access;
    logic        wr_en;
    logic        hit;
    logic [15:0] wmask;
    logic [15:0] wdata16;
    logic        b1_req;
    logic        c2_req;
    logic [2:0]  b1_act;
    logic [1:0]  c2_fb;
    logic [1:0]  ramp_prog;
    logic        rd_first;

    // Writes finish in the first access cycle, reads in the second
    assign access   = psel_i & penable_i;
    assign wr_en    = access & pwrite_i;
    assign rd_first = access & ~pwrite_i & ~rd_wait_r;
    assign wmask   = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign wdata16 = pwdata_i[15:0];

    always_comb begin
        hit = 1'b0;
        unique case (paddr_i)
            `CVLP_ADDR_BUCK1_SLEEP: hit = 1'b1;
            `CVLP_ADDR_CONV2_CTRL:  hit = 1'b1;
            `CVLP_ADDR_SW_SLEEP:    hit = 1'b1;
            default:                hit = 1'b0;
        endcase
    end

    // Register file; state machine reset behaves like power-on reset
    always_comb begin
        buck1_nxt    = buck1_r;
        conv2_nxt    = conv2_r;
        sw_sleep_nxt = sw_sleep_r;
        if (psm_reset_i) begin
            buck1_nxt    = `CVLP_B1_RESET;
            conv2_nxt    = `CVLP_C2_RESET;
            sw_sleep_nxt = 1'b0;
        end else if (wr_en) begin
            // Reserved codes stored unchanged for readback
            unique case (paddr_i)
                `CVLP_ADDR_BUCK1_SLEEP: buck1_nxt = (buck1_r & ~(wmask & `CVLP_B1_MASK))
                                        | (wdata16 & wmask & `CVLP_B1_MASK);
                `CVLP_ADDR_CONV2_CTRL:  conv2_nxt = (conv2_r & ~(wmask & `CVLP_C2_MASK))
                                        | (wdata16 & wmask & `CVLP_C2_MASK);
                `CVLP_ADDR_SW_SLEEP: begin
                    if (pstrb_i[0]) begin
                        sw_sleep_nxt = pwdata_i[0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        prdata_nxt  = prdata_r;
        rd_wait_nxt = rd_first;
        if (rd_first) begin
            unique case (paddr_i)
                `CVLP_ADDR_BUCK1_SLEEP: prdata_nxt = {16'h0000, buck1_r};
                `CVLP_ADDR_CONV2_CTRL:  prdata_nxt = {16'h0000, conv2_r};
                `CVLP_ADDR_SW_SLEEP:    prdata_nxt = {31'h0000_0000, sw_sleep_r};
                default:                prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Read data leaves a flop, so every read costs one wait state
    assign pready_o  = ~rd_first;
    assign prdata_o  = prdata_r;
    assign pslverr_o = access & ~hit;

    cvlp_src_sel u_b1_src (
        .sel_i           (buck1_r[`CVLP_SRC_HI:`CVLP_SRC_LO]),
        .sw_sleep_i      (sw_sleep_r),
        .lowpower_line_i (lowpower_line_i),
        .gpio_sleep_i    (gpio_sleep_i),
        .sleep_req_o     (b1_req)
    );

    cvlp_src_sel u_c2_src (
        .sel_i           (conv2_r[`CVLP_SRC_HI:`CVLP_SRC_LO]),
        .sw_sleep_i      (sw_sleep_r),
        .lowpower_line_i (lowpower_line_i),
        .gpio_sleep_i    (gpio_sleep_i),
        .sleep_req_o     (c2_req)
    );

    assign b1_act    = buck1_r[`CVLP_B1_ACT_HI:`CVLP_B1_ACT_LO];
    assign c2_fb     = conv2_r[`CVLP_C2_FB_HI:`CVLP_C2_FB_LO];
    assign ramp_prog = {conv2_r[`CVLP_C2_RMPH_BIT], conv2_r[`CVLP_C2_RMPL_BIT]};

    // Buck1 decoded controls only act while sleep is requested
    always_comb begin
        buck1_out_nxt                  = '0;
        buck1_out_nxt.sleep_req        = b1_req;
        buck1_out_nxt.alt_voltage_code = buck1_r[`CVLP_B1_ALT_HI:`CVLP_B1_ALT_LO];
        if (b1_req) begin
            unique case (b1_act)
                `CVLP_ACT_KEEP:     ;
                `CVLP_ACT_ALT:      buck1_out_nxt.alt_voltage_en = 1'b1;
                `CVLP_ACT_STBY:     buck1_out_nxt.force_standby  = 1'b1;
                `CVLP_ACT_STBY_ALT: begin
                    buck1_out_nxt.force_standby  = 1'b1;
                    buck1_out_nxt.alt_voltage_en = 1'b1;
                end
                `CVLP_ACT_LDO:      buck1_out_nxt.force_ldo = 1'b1;
                `CVLP_ACT_LDO_ALT:  begin
                    buck1_out_nxt.force_ldo      = 1'b1;
                    buck1_out_nxt.alt_voltage_en = 1'b1;
                end
                `CVLP_ACT_RSVD:     ;
                `CVLP_ACT_OFF:      buck1_out_nxt.output_off = 1'b1;
            endcase
        end
    end

    always_comb begin
        conv2_out_nxt                = conv2_out_r;
        conv2_out_nxt.sleep_req      = c2_req;
        conv2_out_nxt.switch_mode    = conv2_r[`CVLP_C2_TOPO_BIT];
        conv2_out_nxt.output_off     = c2_req & conv2_r[`CVLP_C2_ACT_BIT];
        conv2_out_nxt.low_peak_limit = conv2_r[`CVLP_C2_ILIM_BIT];
        conv2_out_nxt.ramp_code      = (c2_fb == `CVLP_FB_BUS) ? `CVLP_RAMP_LOWEST
                                       : ramp_prog;
        // Reserved feedback holds the last legal source
        unique case (c2_fb)
            `CVLP_FB_EXT:  conv2_out_nxt.feedback = cvlp_pkg::CVLP_FB_EXT_DIV;
            `CVLP_FB_SINK: conv2_out_nxt.feedback = cvlp_pkg::CVLP_FB_SINK_A;
            `CVLP_FB_RSVD: ;
            `CVLP_FB_BUS:  conv2_out_nxt.feedback = cvlp_pkg::CVLP_FB_BUS_DIV;
        endcase
        if (psm_reset_i) begin
            conv2_out_nxt.feedback = cvlp_pkg::CVLP_FB_EXT_DIV;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            buck1_r     <= `CVLP_B1_RESET;
            conv2_r     <= `CVLP_C2_RESET;
            sw_sleep_r  <= 1'b0;
            prdata_r    <= 32'h0000_0000;
            rd_wait_r   <= 1'b0;
            buck1_out_r <= '0;
            conv2_out_r <= '0;
        end else begin
            buck1_r     <= buck1_nxt;
            conv2_r     <= conv2_nxt;
            sw_sleep_r  <= sw_sleep_nxt;
            prdata_r    <= prdata_nxt;
            rd_wait_r   <= rd_wait_nxt;
            buck1_out_r <= buck1_out_nxt;
            conv2_out_r <= conv2_out_nxt;
        end
    end

    assign buck1_o = buck1_out_r;
    assign conv2_o = conv2_out_r;

    AST_B1_OFF: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_req && b1_act == `CVLP_ACT_OFF) |=> buck1_o.output_off)
        else $error("buck1 output not turned off");

    AST_B1_ALT: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_req && b1_act == `CVLP_ACT_ALT) |=>
        (buck1_o.alt_voltage_en && !buck1_o.force_standby && !buck1_o.force_ldo))
        else $error("buck1 alternate voltage not selected");

    AST_B1_AWAKE: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !b1_req |=> !(buck1_o.force_standby || buck1_o.force_ldo || buck1_o.output_off
                      || buck1_o.alt_voltage_en))
        else $error("buck1 mode flag set while awake");

    AST_B1_KEEP: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_act == `CVLP_ACT_KEEP || b1_act == `CVLP_ACT_RSVD) |=>
        !(buck1_o.force_standby || buck1_o.force_ldo || buck1_o.output_off
          || buck1_o.alt_voltage_en))
        else $error("buck1 keep code changed behaviour");

    AST_B1_STBY_ONLY: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_req && b1_act == `CVLP_ACT_STBY) |=>
        (buck1_o.force_standby && !buck1_o.alt_voltage_en && !buck1_o.force_ldo))
        else $error("buck1 standby wrong");

    AST_B1_STBY: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_req && b1_act == `CVLP_ACT_STBY_ALT) |=>
        (buck1_o.force_standby && buck1_o.alt_voltage_en && !buck1_o.force_ldo))
        else $error("buck1 standby with alternate voltage wrong");

    AST_B1_LDO: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_req && b1_act == `CVLP_ACT_LDO) |=>
        (buck1_o.force_ldo && !buck1_o.alt_voltage_en))
        else $error("buck1 linear mode wrong");

    AST_B1_LDO_ALT: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b1_req && b1_act == `CVLP_ACT_LDO_ALT) |=>
        (buck1_o.force_ldo && buck1_o.alt_voltage_en && !buck1_o.force_standby))
        else $error("buck1 linear mode with alternate voltage wrong");

    AST_B1_ALT_CODE: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !rst_i |=>
        (buck1_o.alt_voltage_code == $past(buck1_r[`CVLP_B1_ALT_HI:`CVLP_B1_ALT_LO])))
        else $error("buck1 alternate code not passed on");

    AST_GPIO_SLEEP: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        gpio_sleep_i |=> (buck1_o.sleep_req && conv2_o.sleep_req))
        else $error("gpio sleep input ignored");

    AST_B1_SRC: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!gpio_sleep_i && buck1_r[`CVLP_SRC_HI:`CVLP_SRC_LO] == 2'h2) |=>
        (buck1_o.sleep_req == $past(lowpower_line_i[1])))
        else $error("buck1 sleep source wrong");

    AST_B1_SRC_SW: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!gpio_sleep_i && buck1_r[`CVLP_SRC_HI:`CVLP_SRC_LO] == 2'h0) |=>
        (buck1_o.sleep_req == $past(sw_sleep_r)))
        else $error("buck1 software sleep source wrong");

    AST_C2_SRC: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!gpio_sleep_i && conv2_r[`CVLP_SRC_HI:`CVLP_SRC_LO] == 2'h0) |=>
        (conv2_o.sleep_req == $past(sw_sleep_r)))
        else $error("conv2 sleep source wrong");

    AST_C2_SRC_LINE3: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!gpio_sleep_i && conv2_r[`CVLP_SRC_HI:`CVLP_SRC_LO] == 2'h3) |=>
        (conv2_o.sleep_req == $past(lowpower_line_i[2])))
        else $error("conv2 third line source wrong");

    AST_C2_TOPO: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !rst_i |=> (conv2_o.switch_mode == $past(conv2_r[`CVLP_C2_TOPO_BIT])))
        else $error("conv2 topology wrong");

    AST_C2_OFF: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (c2_req && conv2_r[`CVLP_C2_ACT_BIT]) |=> conv2_o.output_off)
        else $error("conv2 sleep off wrong");

    AST_C2_AWAKE: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!c2_req || !conv2_r[`CVLP_C2_ACT_BIT]) |=> !conv2_o.output_off)
        else $error("conv2 turned off while it should run");

    AST_C2_ILIM: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !rst_i |=> (conv2_o.low_peak_limit == $past(conv2_r[`CVLP_C2_ILIM_BIT])))
        else $error("conv2 peak limit wrong");

    AST_C2_RAMP_PROG: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!rst_i && c2_fb != `CVLP_FB_BUS) |=> (conv2_o.ramp_code == $past(ramp_prog)))
        else $error("programmed ramp code wrong");

    AST_C2_RAMP: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (c2_fb == `CVLP_FB_BUS) |=> (conv2_o.ramp_code == `CVLP_RAMP_LOWEST))
        else $error("ramp override missing");

    AST_C2_FB_EXT: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (c2_fb == `CVLP_FB_EXT) |=> (conv2_o.feedback == cvlp_pkg::CVLP_FB_EXT_DIV))
        else $error("divider pin feedback not selected");

    AST_C2_FB_SINK: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!psm_reset_i && c2_fb == `CVLP_FB_SINK) |=>
        (conv2_o.feedback == cvlp_pkg::CVLP_FB_SINK_A))
        else $error("current sink feedback not selected");

    AST_C2_FB_BUS: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!psm_reset_i && c2_fb == `CVLP_FB_BUS) |=>
        (conv2_o.feedback == cvlp_pkg::CVLP_FB_BUS_DIV))
        else $error("bus divider feedback not selected");

    AST_C2_FB_RSVD: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!psm_reset_i && c2_fb == `CVLP_FB_RSVD) |=> $stable(conv2_o.feedback))
        else $error("reserved feedback changed the source");

    AST_PSM_RST: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        psm_reset_i |=> (buck1_r == `CVLP_B1_RESET && conv2_r == `CVLP_C2_RESET))
        else $error("state machine reset ignored");

    AST_PSM_SLEEP: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        psm_reset_i |=> !sw_sleep_r)
        else $error("state machine reset left software sleep set");

endmodule

// ===== bench/cvlp_regs_tb_top.sv
`timescale 1ns/100ps
`include "cvlp_consts.svh"

module cvlp_regs_tb_top;
    logic                     core_clk_i;
    logic                     rst_i;
    logic                     psm_reset_i;
    logic                     psel_i;
    logic                     penable_i;
    logic                     pwrite_i;
    logic [11:0]              paddr_i;
    logic [31:0]              pwdata_i;
    logic [3:0]               pstrb_i;
    logic                     pready_o;
    logic [31:0]              prdata_o;
    logic                     pslverr_o;
    logic [2:0]               lowpower_line_i;
    logic                     gpio_sleep_i;
    cvlp_pkg::cvlp_buck1_type buck1_o;
    cvlp_pkg::cvlp_conv2_type conv2_o;
    cvlp_pkg::cvlp_fb_type    fb_exp;
    logic [15:0]              r1;
    logic [15:0]              r2;
    logic                     sw;
    logic [2:0]               lpv;
    logic                     gv;
    logic [31:0]              rd;
    logic                     er;
    logic [31:0]              wd1;
    logic [31:0]              wd2;
    int                       err_count;
    int                       num_checks;
    int                       cycles;

    cvlp_regs u_dut (
        .core_clk_i      (core_clk_i),
        .rst_i           (rst_i),
        .psm_reset_i     (psm_reset_i),
        .psel_i          (psel_i),
        .penable_i       (penable_i),
        .pwrite_i        (pwrite_i),
        .paddr_i         (paddr_i),
        .pwdata_i        (pwdata_i),
        .pstrb_i         (pstrb_i),
        .pready_o        (pready_o),
        .prdata_o        (prdata_o),
        .pslverr_o       (pslverr_o),
        .lowpower_line_i (lowpower_line_i),
        .gpio_sleep_i    (gpio_sleep_i),
        .buck1_o         (buck1_o),
        .conv2_o         (conv2_o)
    );

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i   <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        pstrb_i  <= 4'hf;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    function automatic cvlp_pkg::cvlp_buck1_type exp_b1(input logic [15:0] r);
        cvlp_pkg::cvlp_buck1_type e;
        logic [2:0]               a;
        logic [1:0]               s;
        e = '0;
        a = r[14:12];
        s = r[9:8];
        e.sleep_req        = gv | ((s == 2'h0) ? sw : lpv[s-1]);
        e.alt_voltage_code = r[6:0];
        if (e.sleep_req) begin
            e.alt_voltage_en = a inside {3'h1, 3'h3, 3'h5};
            e.force_standby  = a inside {3'h2, 3'h3};
            e.force_ldo      = a inside {3'h4, 3'h5};
            e.output_off     = (a == 3'h7);
        end
        return e;
    endfunction

    task automatic check_outs;
        cvlp_pkg::cvlp_buck1_type eb;
        cvlp_pkg::cvlp_buck1_type gb;
        cvlp_pkg::cvlp_conv2_type ec;
        logic [1:0]               q;
        repeat (3) @(posedge core_clk_i);
        #1;
        eb = exp_b1(r1);
        gb = buck1_o;
        q = r2[9:8];
        ec.sleep_req = gv | ((q == 2'h0) ? sw : lpv[q-1]);
        if (r2[1:0] == 2'h0) fb_exp = cvlp_pkg::CVLP_FB_EXT_DIV;
        if (r2[1:0] == 2'h1) fb_exp = cvlp_pkg::CVLP_FB_SINK_A;
        if (r2[1:0] == 2'h3) fb_exp = cvlp_pkg::CVLP_FB_BUS_DIV;
        ec.switch_mode    = r2[14];
        ec.output_off     = ec.sleep_req & r2[12];
        ec.low_peak_limit = r2[6];
        ec.ramp_code      = (r2[1:0] == 2'h3) ? 2'h3 : r2[4:3];
        ec.feedback       = fb_exp;
        chk(32'(gb), 32'(eb));
        chk(32'(conv2_o), 32'(ec));
    endtask

    task automatic read_back;
        apb(1'b0, `CVLP_ADDR_BUCK1_SLEEP, 32'h0);
        chk(rd, {16'h0, r1});
        apb(1'b0, `CVLP_ADDR_CONV2_CTRL, 32'h0);
        chk(rd, {16'h0, r2});
        apb(1'b0, `CVLP_ADDR_SW_SLEEP, 32'h0);
        chk(rd, {31'h0, sw});
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            tally_and_finish;
        end
    end

    initial begin
        rst_i = 1'b1;
        psm_reset_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'h0;
        lowpower_line_i = 3'h0;
        gpio_sleep_i = 1'b0;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        lpv = 3'h0;
        gv = 1'b0;
        sw = 1'b0;
        r1 = `CVLP_B1_RESET;
        r2 = `CVLP_C2_RESET;
        fb_exp = cvlp_pkg::CVLP_FB_EXT_DIV;
        void'($urandom(74950));
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        read_back;
        check_outs;
        apb(1'b1, 12'h2e0, $urandom);
        chk(32'(er), 32'h1);
        apb(1'b0, 12'h2e0, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        for (int i = 0; i < 48; i++) begin
            wd1 = $urandom;
            wd2 = $urandom;
            sw = 1'($urandom);
            lpv = 3'($urandom);
            gv = ($urandom % 4) == 0;
            // First pass forces every action and feedback code while asleep
            if (i < 8) begin
                wd1[14:12] = i[2:0];
                wd1[9:8] = i[1:0];
                wd1[6:0] = i[0] ? 7'h66 : 7'h00;
                wd2[1:0] = i[1:0];
                sw = 1'b1;
                lpv = 3'h7;
                gv = 1'b0;
            end
            r1 = wd1[15:0] & `CVLP_B1_MASK;
            r2 = wd2[15:0] & `CVLP_C2_MASK;
            apb(1'b1, `CVLP_ADDR_BUCK1_SLEEP, wd1);
            apb(1'b1, `CVLP_ADDR_CONV2_CTRL, wd2);
            apb(1'b1, `CVLP_ADDR_SW_SLEEP, {31'h0, sw});
            lowpower_line_i <= lpv;
            gpio_sleep_i <= gv;
            check_outs;
            read_back;
        end
        sw = 1'b0;
        lpv = 3'h0;
        gv = 1'b0;
        apb(1'b1, `CVLP_ADDR_SW_SLEEP, 32'h0);
        lowpower_line_i <= 3'h0;
        gpio_sleep_i <= 1'b0;
        @(posedge core_clk_i);
        psm_reset_i <= 1'b1;
        @(posedge core_clk_i);
        psm_reset_i <= 1'b0;
        r1 = `CVLP_B1_RESET;
        r2 = `CVLP_C2_RESET;
        check_outs;
        read_back;
        tally_and_finish;
    end
endmodule
